// ===== design/tfd_pkg.sv
// Shared constants and types for the timer fault-disable and transfer glue
package tfd_pkg;
   localparam int NUM_PKT = 8;
   localparam int PKT_W = 3;
   localparam int CH = 32;
   localparam int CH_MON = 31;
   localparam int BANKS = 4;
   localparam int BANK_W = 2;
   localparam int FIELD_W = 32;
   localparam int WORD_W = 96;
   localparam int RAM_DEPTH = 128;
   localparam int RAM_AW = 7;
   localparam int TADDR_W = 11;
   localparam int WORD_LSB = 4;
   localparam int FIELD_DATA_LSB = 0;
   localparam int FIELD_CTRL_LSB = 32;
   localparam int FIELD_PROG_LSB = 64;
   localparam int ADDR_W = 32;
   localparam int ELEM_W = 64;
   localparam int COUNT_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int XFER_W = ADDR_W + ELEM_W + 1;
   localparam logic [1:0] SRC_PORT_PIN = 2'h0;
   localparam logic [1:0] SRC_ENCODER = 2'h1;
   localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
   localparam logic [1:0] MODE_CIRCULAR = 2'h1;
   localparam logic [1:0] MODE_AUTO_SWITCH = 2'h2;
   localparam logic [1:0] MSTEP_FIXED = 2'h0;
   localparam logic [1:0] MSTEP_32 = 2'h1;
   localparam logic [1:0] MSTEP_64 = 2'h2;
   localparam logic [TADDR_W-1:0] TSTEP_8 = 11'h008;
   localparam logic [TADDR_W-1:0] TSTEP_16 = 11'h010;
   localparam logic [ADDR_W-1:0] MSTEP_BYTES_32 = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] MSTEP_BYTES_64 = 32'h0000_0008;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_PUSH = 2'b10
   } tfd_state_t;
endpackage : tfd_pkg

// ===== design/tfd_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tfd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   logic doWrite;
   logic doRead;

   // Extra pointer bit tells full from empty
   assign inReady = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
   assign outValid = (wrPtr != rdPtr);
   assign outData = store[rdPtr[AW-1:0]];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   // Storage
   always_ff @(posedge ref_clk) begin
      if (doWrite) begin
         store[wrPtr[AW-1:0]] <= inData;
      end
   end

   // Pointers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (doWrite) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (doRead) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end
endmodule : tfd_fifo
`default_nettype wire

// ===== design/tfd_timer_glue.sv
// Timer output disable path, transfer unit, timer RAM and monitor hookup
// Notes on behaviour
// - Fault input low releases every timer pin whose disable-mask bit is set.
// - A two-bit select picks port pin five or encoder error as fault source.
// - Encoder error output pulses whenever a quadrature phase error is seen.
// - Encoder error is inverted, then synchronised by two flops on the clock.
// - Port pin five is used as sampled from its input buffer.
// - Request line n triggers control packet n while that packet is active.
// - Eight control packets, each dual-buffered, stored with parity.
// - Each element moves as a 32-bit or 64-bit memory transaction.
// - Timer address steps 8 or 16 bytes; memory address fixed, 4 or 8.
// - Each packet runs one-shot, circular or automatic buffer switch.
// - Transfers leave through a master port, checked against a protection window.
// - Timer RAM has four banks, each writing and reading different words together.
// - RAM words are 96 bits: program, control and data fields of 32.
// - Channel 31 drives the clock of comparator one, counter one.
// - Channel 31 may be internal only; monitor taps timer output directly.
`timescale 1ns/1ps
`default_nettype none
module tfd_timer_glue
   import tfd_pkg::*;
#(
   parameter logic [1:0] SEL_PORT_PIN = tfd_pkg::SRC_PORT_PIN,
   parameter logic [1:0] SEL_ENCODER = tfd_pkg::SRC_ENCODER
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Fault disable sources and control
   input wire logic portPinFive,
   input wire logic encoderA,
   input wire logic encoderB,
   input wire logic [1:0] pinmuxSelect,
   input wire logic [tfd_pkg::CH-1:0] outputDisableMask,
   output logic encoderPhaseError,
   output logic faultDisablePort_n,
   // Timer channels and pins
   input wire logic [tfd_pkg::CH-1:0] timerOut,
   input wire logic [tfd_pkg::CH-1:0] timerDrive,
   input wire logic monitorInternalOnly,
   output logic [tfd_pkg::CH-1:0] pinOut,
   output logic [tfd_pkg::CH-1:0] pinOe_n,
   output logic clockCompareOneClk,
   // Transfer requests and packet configuration
   input wire logic [tfd_pkg::NUM_PKT-1:0] transferRequest,
   input wire logic cfgWrite,
   input wire logic [tfd_pkg::PKT_W-1:0] cfgIndex,
   input wire logic cfgEnable,
   input wire logic [tfd_pkg::TADDR_W-1:0] cfgTimerAddr,
   input wire logic [tfd_pkg::ADDR_W-1:0] cfgMemBaseA,
   input wire logic [tfd_pkg::ADDR_W-1:0] cfgMemBaseB,
   input wire logic [tfd_pkg::COUNT_W-1:0] cfgCount,
   input wire logic [1:0] cfgMode,
   input wire logic cfgWide,
   input wire logic cfgTimerStep16,
   input wire logic [1:0] cfgMemStep,
   // Timer RAM write port
   input wire logic ramWrEn,
   input wire logic [tfd_pkg::RAM_AW-1:0] ramWrAddr,
   input wire logic [tfd_pkg::WORD_W-1:0] ramWrData,
   // System memory master port
   output logic memValid,
   input wire logic memReady,
   output logic [tfd_pkg::ADDR_W-1:0] memAddr,
   output logic [tfd_pkg::ELEM_W-1:0] memData,
   output logic memWide,
   // Protection window and status
   input wire logic [tfd_pkg::ADDR_W-1:0] mpuBase,
   input wire logic [tfd_pkg::ADDR_W-1:0] mpuLimit,
   input wire logic mpuFaultClear,
   input wire logic parityErrorClear,
   input wire logic [tfd_pkg::NUM_PKT-1:0] lostClear,
   output logic mpuFault,
   output logic parityError,
   output logic [tfd_pkg::NUM_PKT-1:0] requestLost,
   output logic [tfd_pkg::NUM_PKT-1:0] packetActive
);
   import tfd_pkg::*;

   // Encoder and fault path
   logic prevA;
   logic prevB;
   logic encSyncA;
   logic encSyncB;
   // Packet storage (static part)
   logic [TADDR_W-1:0] pktTAddr [NUM_PKT];
   logic [ADDR_W-1:0] pktMemA [NUM_PKT];
   logic [ADDR_W-1:0] pktMemB [NUM_PKT];
   logic [COUNT_W-1:0] pktCount [NUM_PKT];
   logic [1:0] pktMode [NUM_PKT];
   logic [NUM_PKT-1:0] pktWide;
   logic [NUM_PKT-1:0] pktStep16;
   logic [1:0] pktMStep [NUM_PKT];
   logic [NUM_PKT-1:0] pktPar;
   // Packet run state
   logic [TADDR_W-1:0] curT [NUM_PKT];
   logic [ADDR_W-1:0] curM [NUM_PKT];
   logic [COUNT_W-1:0] remain [NUM_PKT];
   logic [NUM_PKT-1:0] bufSel;
   logic [NUM_PKT-1:0] pending;
   // Engine
   tfd_state_t state;
   tfd_state_t next_state;
   logic [PKT_W-1:0] cur;
   logic [PKT_W-1:0] pick;
   logic anyPend;
   logic take;
   logic badPar;
   logic done;
   logic mpuOk;
   logic [ELEM_W-1:0] elem;
   // RAM
   logic [RAM_AW-1:0] rdIndex;
   logic [BANK_W-1:0] rdBankQ;
   logic [WORD_W-1:0] bankRd [BANKS];
   logic [WORD_W-1:0] rdWord;
   // FIFO
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [XFER_W-1:0] fifoInData;
   logic [XFER_W-1:0] fifoOutData;

   // Phase error: both quadrature inputs moved in one cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prevA <= 1'b0;
         prevB <= 1'b0;
         encoderPhaseError <= 1'b0;
      end else begin
         prevA <= encoderA;
         prevB <= encoderB;
         encoderPhaseError <= (encoderA != prevA) && (encoderB != prevB);
      end
   end

   // Inverted error through a two-flop synchroniser
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         encSyncA <= 1'b1;
         encSyncB <= 1'b1;
      end else begin
         encSyncA <= ~encoderPhaseError;
         encSyncB <= encSyncA;
      end
   end

   // Source select; codes other than the encoder one fall back to the pin
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         faultDisablePort_n <= 1'b1;
      end else if (pinmuxSelect == SEL_ENCODER) begin
         faultDisablePort_n <= encSyncB;
      end else begin
         faultDisablePort_n <= portPinFive;
      end
   end

   // Pin drivers; enable is active low, so a masked pin floats under fault
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pinOut <= '0;
         pinOe_n <= '1;
      end else begin
         pinOut <= timerOut;
         pinOe_n <= ~(timerDrive & ~(outputDisableMask & {CH{~faultDisablePort_n}}));
         if (monitorInternalOnly) begin
            pinOe_n[CH_MON] <= 1'b1;
         end
      end
   end

   // Monitor tap ahead of the pin buffer, so it works with the pin off
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clockCompareOneClk <= 1'b0;
      end else begin
         clockCompareOneClk <= timerOut[CH_MON];
      end
   end

   // Timer RAM banks; low address bits pick the bank
   assign rdIndex = curT[cur][WORD_LSB +: RAM_AW];
   for (genvar b = 0; b < BANKS; b++) begin : gBank
      logic [WORD_W-1:0] words [RAM_DEPTH/BANKS];
      always_ff @(posedge ref_clk) begin
         if (ramWrEn && ramWrAddr[BANK_W-1:0] == BANK_W'(b)) begin
            words[ramWrAddr[RAM_AW-1:BANK_W]] <= ramWrData;
         end
         bankRd[b] <= words[rdIndex[RAM_AW-1:BANK_W]];
      end
   end
   always_ff @(posedge ref_clk) begin
      rdBankQ <= rdIndex[BANK_W-1:0];
   end
   assign rdWord = bankRd[rdBankQ];

   // Static packet fields and their parity
   always_ff @(posedge ref_clk) begin
      if (cfgWrite) begin
         pktTAddr[cfgIndex] <= cfgTimerAddr;
         pktMemA[cfgIndex] <= cfgMemBaseA;
         pktMemB[cfgIndex] <= cfgMemBaseB;
         pktCount[cfgIndex] <= cfgCount;
         pktMode[cfgIndex] <= cfgMode;
         pktWide[cfgIndex] <= cfgWide;
         pktStep16[cfgIndex] <= cfgTimerStep16;
         pktMStep[cfgIndex] <= cfgMemStep;
         pktPar[cfgIndex] <= ^{cfgTimerAddr, cfgMemBaseA, cfgMemBaseB, cfgCount,
                               cfgMode, cfgWide, cfgTimerStep16, cfgMemStep};
      end
   end

   // Lowest pending packet wins
   always_comb begin
      pick = '0;
      anyPend = 1'b0;
      for (int i = NUM_PKT - 1; i >= 0; i--) begin
         if (pending[i] && packetActive[i]) begin
            pick = PKT_W'(i);
            anyPend = 1'b1;
         end
      end
   end

   assign badPar = pktPar[pick] != ^{pktTAddr[pick], pktMemA[pick], pktMemB[pick], pktCount[pick],
                                     pktMode[pick], pktWide[pick], pktStep16[pick], pktMStep[pick]};
   assign take = (state == ST_IDLE) && anyPend;
   assign mpuOk = (curM[cur] >= mpuBase) && (curM[cur] <= mpuLimit);
   assign elem = pktWide[cur] ? rdWord[FIELD_DATA_LSB +: ELEM_W]
                              : {{FIELD_W{1'b0}}, rdWord[FIELD_DATA_LSB +: FIELD_W]};
   assign done = (state == ST_PUSH) && (fifoInReady || !mpuOk);
   assign fifoInValid = (state == ST_PUSH) && mpuOk;
   assign fifoInData = {curM[cur], elem, pktWide[cur]};

   // Engine sequence; a full FIFO stalls the push
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (anyPend && !badPar) begin
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            next_state = ST_PUSH;
         end
         ST_PUSH: begin
            if (done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         cur <= '0;
      end else begin
         state <= next_state;
         if (take) begin
            cur <= pick;
         end
      end
   end

   // Pending requests; a new request wins over the clear by service
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pending <= '0;
         requestLost <= '0;
      end else begin
         for (int i = 0; i < NUM_PKT; i++) begin
            if (transferRequest[i] && packetActive[i]) begin
               pending[i] <= 1'b1;
            end else if (take && pick == PKT_W'(i)) begin
               pending[i] <= 1'b0;
            end
            if (transferRequest[i] && pending[i] && packetActive[i]) begin
               requestLost[i] <= 1'b1;
            end else if (lostClear[i]) begin
               requestLost[i] <= 1'b0;
            end
         end
      end
   end

   // Sticky error flags; a new event wins over the clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         parityError <= 1'b0;
         mpuFault <= 1'b0;
      end else begin
         if (take && badPar) begin
            parityError <= 1'b1;
         end else if (parityErrorClear) begin
            parityError <= 1'b0;
         end
         if (state == ST_PUSH && !mpuOk) begin
            mpuFault <= 1'b1;
         end else if (mpuFaultClear) begin
            mpuFault <= 1'b0;
         end
      end
   end

   // Run state: address stepping and end-of-buffer handling
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         packetActive <= '0;
         bufSel <= '0;
      end else if (cfgWrite) begin
         packetActive[cfgIndex] <= cfgEnable;
         bufSel[cfgIndex] <= 1'b0;
         curT[cfgIndex] <= cfgTimerAddr;
         curM[cfgIndex] <= cfgMemBaseA;
         remain[cfgIndex] <= cfgCount;
      end else if (done) begin
         if (remain[cur] > COUNT_ONE) begin
            remain[cur] <= remain[cur] - COUNT_ONE;
            curT[cur] <= curT[cur] + (pktStep16[cur] ? TSTEP_16 : TSTEP_8);
            case (pktMStep[cur])
               MSTEP_32: curM[cur] <= curM[cur] + MSTEP_BYTES_32;
               MSTEP_64: curM[cur] <= curM[cur] + MSTEP_BYTES_64;
               default: curM[cur] <= curM[cur];
            endcase
         end else begin
            remain[cur] <= pktCount[cur];
            curT[cur] <= pktTAddr[cur];
            case (pktMode[cur])
               MODE_CIRCULAR: begin
                  curM[cur] <= bufSel[cur] ? pktMemB[cur] : pktMemA[cur];
               end
               MODE_AUTO_SWITCH: begin
                  bufSel[cur] <= ~bufSel[cur];
                  curM[cur] <= bufSel[cur] ? pktMemA[cur] : pktMemB[cur];
               end
               default: begin
                  packetActive[cur] <= 1'b0;
               end
            endcase
         end
      end
   end

   // Eight-entry buffer between engine and master port
   tfd_fifo #(
      .WIDTH(XFER_W),
      .DEPTH(FIFO_DEPTH)
   ) uFifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Master port output stage; holds until the bus accepts
   assign fifoOutReady = !memValid || memReady;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         memValid <= 1'b0;
         memAddr <= '0;
         memData <= '0;
         memWide <= 1'b0;
      end else if (fifoOutReady) begin
         memValid <= fifoOutValid;
         if (fifoOutValid) begin
            {memAddr, memData, memWide} <= fifoOutData;
         end
      end
   end
endmodule : tfd_timer_glue
`default_nettype wire

// ===== tb/tfd_timer_glue_sva.sv
// Concurrent checks on the ports of the timer glue
`timescale 1ns/1ps
`default_nettype none
module tfd_timer_glue_sva
   import tfd_pkg::*;
#(
   parameter logic [1:0] SEL_ENCODER = 2'h1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Fault path
   input wire logic portPinFive,
   input wire logic encoderA,
   input wire logic encoderB,
   input wire logic [1:0] pinmuxSelect,
   input wire logic [tfd_pkg::CH-1:0] outputDisableMask,
   input wire logic encoderPhaseError,
   input wire logic faultDisablePort_n,
   // Pins and monitor
   input wire logic [tfd_pkg::CH-1:0] timerOut,
   input wire logic [tfd_pkg::CH-1:0] timerDrive,
   input wire logic monitorInternalOnly,
   input wire logic [tfd_pkg::CH-1:0] pinOe_n,
   input wire logic clockCompareOneClk,
   // Master port
   input wire logic memValid,
   input wire logic memReady,
   input wire logic [tfd_pkg::ADDR_W-1:0] memAddr,
   input wire logic [tfd_pkg::ELEM_W-1:0] memData,
   input wire logic memWide
);
   logic [2:0] rstAge;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Cycles since reset, so no check looks back into a reset cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rstAge <= 3'h0;
      end else if (rstAge != 3'h7) begin
         rstAge <= rstAge + 3'h1;
      end
   end
   // Encoder chosen as source for the whole trip through the synchroniser
   sequence s_enc_held;
      (pinmuxSelect == SEL_ENCODER) [*4];
   endsequence
   a_pin_source: assert property (rstAge != 3'h0 && $past(pinmuxSelect) != SEL_ENCODER
      |-> faultDisablePort_n == $past(portPinFive)) else $error("Fault input does not follow port pin five");
   a_encoder_sync: assert property ((rstAge >= 3'h3) ##0 s_enc_held
      |-> faultDisablePort_n == !$past(encoderPhaseError, 3)) else $error("Encoder error path latency or polarity");
   a_phase_error: assert property (rstAge >= 3'h3 |-> encoderPhaseError ==
      ($past(encoderA, 1) != $past(encoderA, 2) && $past(encoderB, 1) != $past(encoderB, 2)))
      else $error("Phase error pulse does not match encoder inputs");
   a_fault_release: assert property (rstAge != 3'h0 && !$past(faultDisablePort_n)
      |-> (~pinOe_n & $past(outputDisableMask)) == 32'h0000_0000) else $error("Masked pin driven under fault");
   a_drive_enable: assert property (rstAge != 3'h0 && $past(faultDisablePort_n)
      |-> pinOe_n[30:0] == ~$past(timerDrive[30:0])) else $error("Pin enable does not follow timer drive");
   a_internal_only: assert property (rstAge != 3'h0 && $past(monitorInternalOnly)
      |-> pinOe_n[CH_MON]) else $error("Internal-only channel reached its pin");
   a_monitor_tap: assert property (rstAge != 3'h0
      |-> clockCompareOneClk == $past(timerOut[CH_MON])) else $error("Comparator clock does not follow channel");
   a_mem_hold: assert property (memValid && !memReady
      |=> memValid && $stable(memAddr) && $stable(memData) && $stable(memWide)) else $error("Master request dropped");
   a_mem_narrow: assert property (memValid && !memWide
      |-> memData[63:32] == 32'h0000_0000) else $error("Narrow element has upper bits set");
endmodule : tfd_timer_glue_sva
bind tfd_timer_glue tfd_timer_glue_sva #(.SEL_ENCODER(SEL_ENCODER)) u_sva (.ref_clk, .reset, .portPinFive,
   .encoderA, .encoderB, .pinmuxSelect, .outputDisableMask, .encoderPhaseError, .faultDisablePort_n, .timerOut,
   .timerDrive, .monitorInternalOnly, .pinOe_n, .clockCompareOneClk, .memValid, .memReady, .memAddr, .memData,
   .memWide);
`default_nettype wire

// ===== tb/tfd_mem_model.sv
// System memory slave that logs every accepted element
`timescale 1ns/1ps
`default_nettype none
module tfd_mem_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Stall control
   input wire logic slow,
   input wire logic stall,
   // Master port of the transfer unit
   input wire logic memValid,
   input wire logic [31:0] memAddr,
   input wire logic [63:0] memData,
   output logic memReady
);
   logic [31:0] qa[$];
   logic [63:0] qd[$];
   logic [7:0] lfsr;
   // Random ready while slow, none while stalled, so stalls of any length hit the port
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lfsr <= 8'hA5;
         memReady <= 1'b0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         memReady <= stall ? 1'b0 : (slow ? lfsr[0] : 1'b1);
         if (memValid && memReady) begin
            qa.push_back(memAddr);
            qd.push_back(memData);
         end
      end
   end
endmodule : tfd_mem_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the timer glue and its FIFO
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tfd_pkg::*;
   `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
   logic ref_clk = 0, reset = 1, portPinFive = 1, encoderA = 0, encoderB = 0, monitorInternalOnly = 0, slow = 0;
   logic cfgWrite = 0, cfgEnable = 0, cfgWide = 0, cfgTimerStep16 = 0, ramWrEn = 0, mpuFaultClear = 0;
   logic [1:0] pinmuxSelect = 0, cfgMode = 0, cfgMemStep = 0;
   logic [CH-1:0] outputDisableMask = 0, timerOut = 0, timerDrive = 0, pinOut, pinOe_n;
   logic [NUM_PKT-1:0] transferRequest = 0, requestLost, packetActive;
   logic [PKT_W-1:0] cfgIndex = 0;
   logic [TADDR_W-1:0] cfgTimerAddr = 0;
   logic [ADDR_W-1:0] cfgMemBaseA = 0, cfgMemBaseB = 0, mpuBase = 0, mpuLimit = 0, memAddr, ea;
   logic [COUNT_W-1:0] cfgCount = 0;
   logic [RAM_AW-1:0] ramWrAddr = 0;
   logic [WORD_W-1:0] ramWrData = 0, ramImg [16];
   logic [ELEM_W-1:0] memData, ed;
   logic encoderPhaseError, faultDisablePort_n, clockCompareOneClk, memValid, memReady, memWide, mpuFault, parityError;
   logic seen, stall = 0;
   logic [31:0] seed = 32'd71417;
   int bad_count = 0, num_checks = 0, qi;
   // Parity and lost clears stay low: no scenario provokes parity or lost requests
   tfd_timer_glue u_tfd_timer_glue (.ref_clk, .reset, .portPinFive, .encoderA, .encoderB, .pinmuxSelect,
      .outputDisableMask, .encoderPhaseError, .faultDisablePort_n, .timerOut, .timerDrive, .monitorInternalOnly,
      .pinOut, .pinOe_n, .clockCompareOneClk, .transferRequest, .cfgWrite, .cfgIndex, .cfgEnable, .cfgTimerAddr,
      .cfgMemBaseA, .cfgMemBaseB, .cfgCount, .cfgMode, .cfgWide, .cfgTimerStep16, .cfgMemStep, .ramWrEn,
      .ramWrAddr, .ramWrData, .memValid, .memReady, .memAddr, .memData, .memWide, .mpuBase, .mpuLimit,
      .mpuFaultClear, .parityErrorClear(1'b0), .lostClear(8'h00), .mpuFault, .parityError, .requestLost,
      .packetActive);
   tfd_mem_model u_tfd_mem_model (.ref_clk, .reset, .slow, .stall, .memValid, .memAddr, .memData, .memReady);
   // 40 MHz clock
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Element k of packet n: buffer B only after auto switch, index wraps at the count of two
   function automatic void expect_elem(input int n, input int k, output logic [31:0] a, output logic [63:0] d);
      int b, i, ms, w;
      b = (k >= 2 && n % 3 == 2) ? 1 : 0;
      i = k % 2;
      ms = ((n >> 1) % 3) * 4;
      a = 32'h2000_0000 + 32'(n * 256 + b * 128 + i * ms);
      w = (n * 32 + i * (n[2] ? 8 : 16)) >> 4;
      d = n[0] ? ramImg[w][63:0] : {32'h0000_0000, ramImg[w][31:0]};
   endfunction : expect_elem
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : step
   task test_done;
      $display("checks=%0d bad=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Bounded wait for the slave to log a number of elements
   task wait_mem(input int want);
      for (int i = 0; i < 400 && u_tfd_mem_model.qa.size() < want; i++) step(1);
      if (u_tfd_mem_model.qa.size() < want) begin
         bad_count++;
         test_done();
      end
   endtask : wait_mem
   // Main sequence
   initial begin
      step(16);
      reset = 0;
      step(1);
      // Pin source under every code but the encoder one
      for (int s = 0; s < 4; s++) begin
         if (s == 1) continue;
         pinmuxSelect = 2'(s);
         outputDisableMask = rnd();
         timerDrive = 32'hFFFF_FFFF;
         portPinFive = 0;
         step(3);
         `CHK(pinOe_n, outputDisableMask)
         portPinFive = 1;
         step(3);
         `CHK(pinOe_n, 32'h0000_0000)
      end
      // Encoder source: a low pin is ignored, only a double toggle faults
      pinmuxSelect = SRC_ENCODER;
      portPinFive = 0;
      step(5);
      `CHK(faultDisablePort_n, 1'b1)
      for (int k = 0; k < 2; k++) begin
         seen = 0;
         encoderA = ~encoderA;
         if (k == 1) encoderB = ~encoderB;
         for (int i = 0; i < 8; i++) begin
            step(1);
            if (faultDisablePort_n === 1'b0) seen = 1;
         end
         `CHK(seen, k[0])
      end
      // Channel 31 kept internal while the comparator still sees it
      pinmuxSelect = SRC_PORT_PIN;
      portPinFive = 1;
      monitorInternalOnly = 1;
      repeat (6) begin
         timerOut = rnd();
         step(1);
         `CHK(clockCompareOneClk, timerOut[CH_MON])
         `CHK({pinOe_n[CH_MON], pinOut}, {1'b1, timerOut})
      end
      monitorInternalOnly = 0;
      // Timer RAM image, back to back across the banks
      ramWrEn = 1;
      for (int w = 0; w < 16; w++) begin
         ramImg[w] = {rnd(), rnd(), rnd()};
         ramWrAddr = 7'(w);
         ramWrData = ramImg[w];
         step(1);
      end
      ramWrEn = 0;
      mpuLimit = 32'hFFFF_FFFF;
      // Eight packets covering every mode, width and step
      cfgWrite = 1;
      cfgEnable = 1;
      cfgCount = 8'h02;
      for (int n = 0; n < 8; n++) begin
         cfgIndex = 3'(n);
         cfgTimerAddr = TADDR_W'(n * 32);
         cfgMemBaseA = 32'h2000_0000 + 32'(n * 256);
         cfgMemBaseB = cfgMemBaseA + 32'h0000_0080;
         cfgMode = 2'(n % 3);
         cfgWide = n[0];
         cfgTimerStep16 = ~n[2];
         cfgMemStep = 2'((n >> 1) % 3);
         step(1);
      end
      cfgWrite = 0;
      // Three rounds of simultaneous requests, the second against a stalling slave
      for (int k = 0; k < 3; k++) begin
         slow = (k == 1);
         transferRequest = 8'hFF;
         step(1);
         transferRequest = 8'h00;
         wait_mem(k == 2 ? 21 : 8 * (k + 1));
         step(2);
         if (k == 1) `CHK(packetActive, 8'hB6)
      end
      step(20);
      `CHK(u_tfd_mem_model.qa.size(), 21)
      qi = 0;
      for (int k = 0; k < 3; k++) begin
         for (int n = 0; n < 8; n++) begin
            if (k == 2 && n % 3 == 0) continue;
            expect_elem(n, k, ea, ed);
            `CHK(u_tfd_mem_model.qa[qi], ea)
            `CHK(u_tfd_mem_model.qd[qi], ed)
            qi++;
         end
      end
      // Element outside the protection window is dropped and flagged
      mpuLimit = 32'h1FFF_FFFF;
      transferRequest = 8'h02;
      step(1);
      transferRequest = 8'h00;
      for (int i = 0; i < 50 && mpuFault !== 1'b1; i++) step(1);
      `CHK(mpuFault, 1'b1)
      step(10);
      `CHK(u_tfd_mem_model.qa.size(), 21)
      mpuFaultClear = 1;
      step(2);
      mpuFaultClear = 0;
      `CHK(mpuFault, 1'b0)
      // Stalled port: of twelve elements nine fill output stage and FIFO, one push waits, two stay pending, then all drain in order
      mpuLimit = 32'hFFFF_FFFF;
      stall = 1;
      for (int j = 0; j < 3; j++) begin
         transferRequest = 8'hB4;
         step(1);
         transferRequest = 8'h00;
         step(20);
      end
      `CHK({requestLost, parityError, memValid, 32'(u_tfd_mem_model.qa.size())}, {8'h00, 1'b0, 1'b1, 32'd21})
      stall = 0;
      wait_mem(33);
      `CHK(u_tfd_mem_model.qa.size(), 33)
      for (int j = 0; j < 3; j++) begin
         for (int n = 2; n < 8; n++) begin
            if (n == 3 || n == 6) continue;
            expect_elem(n, (j + 3) % 4, ea, ed);
            `CHK(u_tfd_mem_model.qa[qi], ea)
            `CHK(u_tfd_mem_model.qd[qi], ed)
            qi++;
         end
      end
      test_done();
   end
endmodule : tb
`default_nettype wire
